// ### core/gds_gpio_core.sv
// GPIO upper pin data, interrupt flags for all pins and lower interrupt enables
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "gds_gpio_map.svh"

module gds_gpio_core #(
	parameter int HALF_W = `GDS_HALF_W
)
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [31:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire logic [31:0] i_pin_in,
	output logic [15:0] o_pin_out,
	output logic [15:0] o_pin_oe,
	input wire gds_pkg::gds_cfg_t i_cfg,
	output logic o_irq
);

	//----------------------------------------------------------------
	// Elaboration checks
	//----------------------------------------------------------------

	// Register layout is fixed at sixteen pins per half
	if (HALF_W != `GDS_HALF_W)
	begin : g_bad_width
		$error("HALF_W must be 16");
	end

	//----------------------------------------------------------------
	// Reset release
	//----------------------------------------------------------------

	logic [1:0] rst_sync_ff;
	logic rst_n;

	// Assert at once, release two edges later so no flop sees a runt release
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end

	assign rst_n = rst_sync_ff[1];

	//----------------------------------------------------------------
	// Helpers
	//----------------------------------------------------------------

	// Address match, used by every register
	function automatic logic hit(input logic [31:0] addr, input logic [31:0] off);
		hit = (addr == off);
	endfunction

	localparam gds_pkg::gds_state_t ST_RST = '{
		pin_s1: `GDS_RST_WORD,
		pin_s2: `GDS_RST_WORD,
		pin_prev: `GDS_RST_WORD,
		data_hi: `GDS_RST_HALF,
		flags: `GDS_RST_WORD,
		en_lo: `GDS_RST_HALF,
		pass: {`GDS_RST_PASS, `GDS_RST_PASS},
		rdata: `GDS_RST_HALF,
		irq: 1'b0,
		pin_out: `GDS_RST_HALF,
		pin_oe: `GDS_RST_HALF
	};

	gds_pkg::gds_state_t st_ff;
	gds_pkg::gds_state_t nxt_st;
	gds_pkg::gds_word_t set_vec;
	gds_pkg::gds_word_t en_all;
	gds_pkg::gds_half_t pin_view_hi;

	//----------------------------------------------------------------
	// Event detection
	//----------------------------------------------------------------

	// Low half enables live here, upper half come from the unit
	assign en_all = {i_cfg.en_hi, st_ff.en_lo};

	// Pin 15 (carrier detect) is sampled like any other input pin
	for (genvar k = 0; k < 32; k++)
	begin : g_det
		// Edge mode fires on any change, level mode while at the chosen level
		assign set_vec[k] = en_all[k] & (i_cfg.trig[k] ?
			(st_ff.pin_s2[k] ^ st_ff.pin_prev[k]) :
			(st_ff.pin_s2[k] == i_cfg.lvl[k]));
	end

	// Output pins read back the written data, input pins their sampled level
	for (genvar k = 0; k < 16; k++)
	begin : g_view
		assign pin_view_hi[k] = i_cfg.dir_hi[k] ? st_ff.data_hi[k] : st_ff.pin_s2[k + 16];
	end

	//----------------------------------------------------------------
	// Next state
	//----------------------------------------------------------------

	always_comb
	begin
		nxt_st = st_ff;
		// Two flops before anything looks at a pin
		nxt_st.pin_s1 = i_pin_in;
		nxt_st.pin_s2 = st_ff.pin_s1;
		nxt_st.pin_prev = st_ff.pin_s2;
		// Writes; data bits are stored even for input pins but never driven
		if (i_wr && hit(i_addr, `GDS_OFF_PIN_DATA_HIGH))
			nxt_st.data_hi = i_wdata;
		if (i_wr && hit(i_addr, `GDS_OFF_IRQ_ENABLE_LOW))
			nxt_st.en_lo = i_wdata;
		if (i_wr && hit(i_addr, `GDS_OFF_IRQ_PASS_LOW))
			nxt_st.pass[15:0] = i_wdata;
		if (i_wr && hit(i_addr, `GDS_OFF_IRQ_PASS_HIGH))
			nxt_st.pass[31:16] = i_wdata;
		// Write-one clears, but a new event in the same cycle wins
		if (i_wr && hit(i_addr, `GDS_OFF_IRQ_FLAGS_LOW))
			nxt_st.flags[15:0] = st_ff.flags[15:0] & ~i_wdata;
		if (i_wr && hit(i_addr, `GDS_OFF_IRQ_FLAGS_HIGH))
			nxt_st.flags[31:16] = st_ff.flags[31:16] & ~i_wdata;
		nxt_st.flags = nxt_st.flags | set_vec;
		// Read data lands in the cycle after the strobe; unmapped reads give zero
		nxt_st.rdata = 16'h0000;
		if (i_rd)
		begin
			if (hit(i_addr, `GDS_OFF_PIN_DATA_HIGH))
				nxt_st.rdata = pin_view_hi;
			else if (hit(i_addr, `GDS_OFF_IRQ_FLAGS_LOW))
				nxt_st.rdata = st_ff.flags[15:0];
			else if (hit(i_addr, `GDS_OFF_IRQ_FLAGS_HIGH))
				nxt_st.rdata = st_ff.flags[31:16];
			else if (hit(i_addr, `GDS_OFF_IRQ_ENABLE_LOW))
				nxt_st.rdata = st_ff.en_lo;
			else if (hit(i_addr, `GDS_OFF_IRQ_PASS_LOW))
				nxt_st.rdata = st_ff.pass[15:0];
			else if (hit(i_addr, `GDS_OFF_IRQ_PASS_HIGH))
				nxt_st.rdata = st_ff.pass[31:16];
		end
		// Registered so the request line never glitches
		nxt_st.irq = |(nxt_st.flags & nxt_st.pass);
		// Pin drivers follow direction and data one edge later
		nxt_st.pin_oe = i_cfg.dir_hi;
		nxt_st.pin_out = nxt_st.data_hi;
	end

	//----------------------------------------------------------------
	// State register
	//----------------------------------------------------------------

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end

	//----------------------------------------------------------------
	// Outputs
	//----------------------------------------------------------------

	assign o_rdata = st_ff.rdata;
	assign o_irq = st_ff.irq;
	assign o_pin_out = st_ff.pin_out;
	assign o_pin_oe = st_ff.pin_oe;

	//----------------------------------------------------------------
	// Assertions
	//----------------------------------------------------------------

	default clocking cb @(posedge i_clk);
	endclocking

	default disable iff (!rst_n);

	// Reading the low flags returns the value held at the strobe
	property p_rd_flags;
		i_rd && hit(i_addr, `GDS_OFF_IRQ_FLAGS_LOW) |=> o_rdata == $past(st_ff.flags[15:0]);
	endproperty
	a_rd_flags: assert property (p_rd_flags) else $error("flag read data wrong");

	// An input pin reads back its synchronised level
	property p_rd_input;
		i_rd && hit(i_addr, `GDS_OFF_PIN_DATA_HIGH) && !i_cfg.dir_hi[0]
			|=> o_rdata[0] == $past(st_ff.pin_s2[16]);
	endproperty
	a_rd_input: assert property (p_rd_input) else $error("input pin read wrong");

	// Driver enable follows direction after one edge
	property p_oe;
		##1 o_pin_oe == $past(i_cfg.dir_hi);
	endproperty
	a_oe: assert property (p_oe) else $error("pin enable wrong");

	// A written data bit is still on the pin two edges after the write when no write follows
	property p_drive;
		i_wr && hit(i_addr, `GDS_OFF_PIN_DATA_HIGH) ##1 !i_wr |=> o_pin_out == $past(i_wdata, 2);
	endproperty
	a_drive: assert property (p_drive) else $error("pin drive wrong");

	// Write-one clears the low flags unless a new event arrives
	property p_w1c;
		i_wr && hit(i_addr, `GDS_OFF_IRQ_FLAGS_LOW) && set_vec[15:0] == 16'h0000
			|=> (st_ff.flags[15:0] & $past(i_wdata)) == 16'h0000;
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared");

	// Without a clearing write a set high flag stays set
	property p_sticky;
		!(i_wr && hit(i_addr, `GDS_OFF_IRQ_FLAGS_HIGH))
			|=> (($past(st_ff.flags[31:16]) & ~st_ff.flags[31:16]) == 16'h0000);
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");

	// A disabled lower pin never raises its flag
	property p_disabled;
		##1 ((st_ff.flags[15:0] & ~$past(st_ff.flags[15:0]) & ~$past(st_ff.en_lo)) == 16'h0000);
	endproperty
	a_disabled: assert property (p_disabled) else $error("flag set while disabled");

	// Any change on an enabled edge pin sets its flag next edge
	property p_edge;
		i_cfg.en_hi[0] && i_cfg.trig[16] && $changed(st_ff.pin_s2[16]) |=> st_ff.flags[16];
	endproperty
	a_edge: assert property (p_edge) else $error("edge missed");

	// Level mode sets the flag while the pin sits at the active level
	property p_level;
		st_ff.en_lo[0] && !i_cfg.trig[0] && st_ff.pin_s2[0] == i_cfg.lvl[0] |=> st_ff.flags[0];
	endproperty
	a_level: assert property (p_level) else $error("level missed");

	// Request line mirrors any passed flag
	property p_irq;
		o_irq == |(st_ff.flags & st_ff.pass);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt line wrong");

	// Reading the low enables returns the stored bits
	property p_rd_enable;
		i_rd && hit(i_addr, `GDS_OFF_IRQ_ENABLE_LOW) |=> o_rdata == $past(st_ff.en_lo);
	endproperty
	a_rd_enable: assert property (p_rd_enable) else $error("enable read data wrong");

	// Reading the high flags returns the value held at the strobe
	property p_rd_high;
		i_rd && hit(i_addr, `GDS_OFF_IRQ_FLAGS_HIGH) |=> o_rdata == $past(st_ff.flags[31:16]);
	endproperty
	a_rd_high: assert property (p_rd_high) else $error("high flag read data wrong");

	// An output pin reads back the data last written to it
	property p_rd_output;
		i_rd && hit(i_addr, `GDS_OFF_PIN_DATA_HIGH) && i_cfg.dir_hi[0]
			|=> o_rdata[0] == $past(st_ff.data_hi[0]);
	endproperty
	a_rd_output: assert property (p_rd_output) else $error("output pin read wrong");

	// Written data reaches the pin driver one edge after the write
	property p_pin_out;
		i_wr && hit(i_addr, `GDS_OFF_PIN_DATA_HIGH) |=> o_pin_out == $past(i_wdata);
	endproperty
	a_pin_out: assert property (p_pin_out) else $error("pin data late");

	// Write-one clears the high flags unless a new event arrives
	property p_w1c_high;
		i_wr && hit(i_addr, `GDS_OFF_IRQ_FLAGS_HIGH) && set_vec[31:16] == 16'h0000
			|=> (st_ff.flags[31:16] & $past(i_wdata)) == 16'h0000;
	endproperty
	a_w1c_high: assert property (p_w1c_high) else $error("high flag not cleared");

	// A qualifying event sets its flag even against a clearing write
	property p_set_wins;
		set_vec[0] |=> st_ff.flags[0];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

	// Without a clearing write a set low flag stays set
	property p_sticky_low;
		!(i_wr && hit(i_addr, `GDS_OFF_IRQ_FLAGS_LOW))
			|=> (($past(st_ff.flags[15:0]) & ~st_ff.flags[15:0]) == 16'h0000);
	endproperty
	a_sticky_low: assert property (p_sticky_low) else $error("low flag lost");

	// A disabled upper pin never raises its flag
	property p_disabled_high;
		##1 ((st_ff.flags[31:16] & ~$past(st_ff.flags[31:16]) & ~$past(i_cfg.en_hi)) == 16'h0000);
	endproperty
	a_disabled_high: assert property (p_disabled_high) else $error("high flag set while disabled");

	// Edge mode stays quiet while the pin holds its level
	property p_edge_quiet;
		i_cfg.en_hi[0] && i_cfg.trig[16] && !$changed(st_ff.pin_s2[16]) && !st_ff.flags[16]
			|=> !st_ff.flags[16];
	endproperty
	a_edge_quiet: assert property (p_edge_quiet) else $error("edge flag without change");

endmodule

`default_nettype wire

// ### core/gds_gpio_map.svh
// Register offsets, reset values and field positions of the GPIO data and interrupt status block
//----------------------------------------------------------------
// Behaviour
// - Upper data bit 0 is pin 16
// - Output pin drives last written data bit
// - Data one drives high, zero low
// - Data write never reaches an input pin
// - Input pin reads back its sampled level
// - Flag reads one after event, write-one clears
// - Low flags pins 15..0, high 31..16
// - Low flags set only when enabled and matching
// - High flags use the upper settings
// - Enable one permits detection, zero forbids
// - Low enable bit 0 is pin 0
// - Pin 15 is carrier detect, input only
// - Direction one is output, reset to input
// - Trigger one is any edge, zero level
// - Active level one is high, zero low
//----------------------------------------------------------------
`ifndef GDS_GPIO_MAP_SVH
`define GDS_GPIO_MAP_SVH

`define GDS_OFF_PIN_DATA_HIGH 32'h0B00_0106
`define GDS_OFF_IRQ_FLAGS_LOW 32'h0B00_0108
`define GDS_OFF_IRQ_FLAGS_HIGH 32'h0B00_010A
`define GDS_OFF_IRQ_ENABLE_LOW 32'h0B00_010C
`define GDS_OFF_IRQ_PASS_LOW 32'h0B00_0120
`define GDS_OFF_IRQ_PASS_HIGH 32'h0B00_0122

`define GDS_RST_HALF 16'h0000
`define GDS_RST_PASS 16'hFFFF
`define GDS_RST_WORD 32'h0000_0000
`define GDS_CARRIER_PIN 15
`define GDS_HALF_W 16

`endif

// ### core/gds_pkg.sv
// Types shared by the GPIO data and interrupt status block
package gds_pkg;

	typedef logic [15:0] gds_half_t;
	typedef logic [31:0] gds_word_t;

	// Settings owned by the rest of the GPIO unit
	typedef struct packed
	{
		gds_half_t dir_hi;
		gds_half_t en_hi;
		gds_word_t trig;
		gds_word_t lvl;
	} gds_cfg_t;

	// Whole state of the block
	typedef struct packed
	{
		gds_word_t pin_s1;
		gds_word_t pin_s2;
		gds_word_t pin_prev;
		gds_half_t data_hi;
		gds_word_t flags;
		gds_half_t en_lo;
		gds_word_t pass;
		gds_half_t rdata;
		logic irq;
		gds_half_t pin_out;
		gds_half_t pin_oe;
	} gds_state_t;

endpackage

// ### tb/gds_pin_model.sv
// Far-side pin model: each upper pin level from the block drive and the external source, lower pins from the external source alone
`timescale 1ns/1ps
`default_nettype none

module gds_pin_model
(
	input wire logic [15:0] i_pin_out,
	input wire logic [15:0] i_pin_oe,
	input wire logic [31:0] i_ext,
	output logic [31:0] o_pin_in
);
	// Driven pins follow the block, the rest the outside world; the external side
	// is assumed to let go of a pin while the block drives it
	always_comb
	begin
		o_pin_in[15:0] = i_ext[15:0];
		for (int k = 0; k < 16; k++)
			o_pin_in[16 + k] = i_pin_oe[k] ? i_pin_out[k] : i_ext[16 + k];
	end
endmodule
`default_nettype wire

// ### tb/gds_gpio_core_bench.sv
// Self-checking bench for the GPIO data and interrupt flag block
`timescale 1ns/1ps
`default_nettype none
`include "gds_gpio_map.svh"

module gds_gpio_core_bench;
	localparam logic [31:0] DH = `GDS_OFF_PIN_DATA_HIGH;
	localparam logic [31:0] FL = `GDS_OFF_IRQ_FLAGS_LOW;
	localparam logic [31:0] FH = `GDS_OFF_IRQ_FLAGS_HIGH;
	localparam logic [31:0] EL = `GDS_OFF_IRQ_ENABLE_LOW;
	localparam logic [31:0] PL = `GDS_OFF_IRQ_PASS_LOW;
	localparam logic [31:0] PH = `GDS_OFF_IRQ_PASS_HIGH;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [31:0] i_addr = 32'h0;
	logic [15:0] i_wdata = 16'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [15:0] o_rdata;
	logic [31:0] pin_level;
	logic [31:0] ext = 32'h0;
	logic [15:0] o_pin_out;
	logic [15:0] o_pin_oe;
	gds_pkg::gds_cfg_t i_cfg = '0;
	logic o_irq;
	int failures = 0;
	int cmp_count = 0;

	always #2.5 i_clk = ~i_clk;

	gds_gpio_core u_gds_gpio_core (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(pin_level), .o_pin_out(o_pin_out),
		.o_pin_oe(o_pin_oe), .i_cfg(i_cfg), .o_irq(o_irq));
	gds_pin_model u_gds_pin_model (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_ext(ext), .o_pin_in(pin_level));

	//----------------------------------------
	// Bus and compare helpers
	//----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there
	task automatic rd(input logic [31:0] a, input logic [15:0] exp);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	//----------------------------------------
	// Scenarios
	//----------------------------------------
	task automatic t_reset;
		rd(DH, 16'h0000);
		rd(FL, 16'h0000);
		rd(FH, 16'h0000);
		rd(EL, 16'h0000);
		rd(PL, 16'hFFFF);
		rd(PH, 16'hFFFF);
		rd(32'h0B00_0100, 16'h0000);
		chk(o_pin_oe, 16'h0000);
		chk(o_pin_out, 16'h0000);
		chk({15'h0, o_irq}, 16'h0000);
	endtask

	// Half the upper pins out, half in; then swap directions
	task automatic t_data;
		@(posedge i_clk);
		i_cfg.dir_hi <= 16'h00FF;
		ext <= 32'h5A00_0000;
		wr(DH, 16'hA5C3);
		cyc(3);
		chk(o_pin_oe, 16'h00FF);
		chk(o_pin_out, 16'hA5C3);
		chk(pin_level[31:16], 16'h5AC3);
		rd(DH, 16'h5AC3);
		// Configuration moves on a rising edge like every other input
		@(posedge i_clk);
		i_cfg.dir_hi <= 16'hFF00;
		cyc(4);
		chk(pin_level[31:16], 16'hA500);
		rd(DH, 16'hA500);
		@(posedge i_clk);
		i_cfg.dir_hi <= 16'h0000;
		ext <= 32'h0;
		cyc(4);
	endtask

	// Both edges on pin 16; pin 17 toggles while disabled
	task automatic t_edge;
		@(posedge i_clk);
		i_cfg.trig <= 32'h0003_0000;
		i_cfg.en_hi <= 16'h0001;
		ext <= 32'h0003_0000;
		cyc(5);
		rd(FH, 16'h0001);
		chk({15'h0, o_irq}, 16'h0001);
		wr(FH, 16'hFFFE);
		cyc(5);
		rd(FH, 16'h0001);
		wr(FH, 16'h0001);
		rd(FH, 16'h0000);
		chk({15'h0, o_irq}, 16'h0000);
		@(posedge i_clk);
		ext <= 32'h0;
		cyc(5);
		rd(FH, 16'h0001);
		@(posedge i_clk);
		i_cfg.en_hi <= 16'h0000;
		wr(FH, 16'hFFFF);
		rd(FH, 16'h0000);
	endtask

	// Pin 0 high-active, pin 15 low-active, pin 1 active but disabled
	task automatic t_level;
		@(posedge i_clk);
		i_cfg.trig <= 32'h0;
		i_cfg.lvl <= 32'h0000_0001;
		ext <= 32'h0000_0001;
		wr(EL, 16'h8001);
		rd(EL, 16'h8001);
		cyc(3);
		rd(FL, 16'h8001);
		chk({15'h0, o_irq}, 16'h0001);
		wr(PL, 16'h0000);
		cyc(2);
		chk({15'h0, o_irq}, 16'h0000);
		wr(PL, 16'hFFFF);
		wr(EL, 16'h0000);
		wr(FL, 16'hFFFF);
		rd(FL, 16'h0000);
	endtask

	task automatic complete_run;
		if (failures == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Main sequence: reset for five cycles, wait out the internal release
	initial
	begin
		repeat (5) @(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_clk);
		t_reset;
		t_data;
		t_edge;
		t_level;
		complete_run;
	end

	// Cuts a hang short
	initial
	begin
		#100000;
		failures++;
		complete_run;
	end
endmodule
`default_nettype wire
